// [pkg/board_glue_pkg.sv]
// shared constants and carriers for the board area decode and nmi gating
`default_nettype none
package board_glue_pkg;
  // cpu area codes
  localparam logic [2:0] AREA_0 = 3'h0;
  localparam logic [2:0] AREA_1 = 3'h1;
  localparam logic [2:0] AREA_2 = 3'h2;
  localparam logic [2:0] AREA_3 = 3'h3;
  localparam logic [2:0] AREA_4 = 3'h4;
  localparam logic [2:0] AREA_5 = 3'h5;
  localparam logic [2:0] AREA_6 = 3'h6;
  // area 0 eprom offset width in bits: 512 kbytes socket window
  localparam int EPROM_ADDR_BITS = 19;
  localparam int AREA_ADDR_BITS = 26;
  // bus width codes
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  // nmi mask register bit positions
  localparam int MASK_EXT_NMI_BIT = 0;
  localparam int MASK_UPPER_EN_BIT = 1;
  localparam logic [7:0] NMI_MASK_RESET = 8'h00;
  // power-on strap capture delay, cycles after reset release
  localparam logic [3:0] STRAP_SETTLE_CYCLES = 4'h8;

  typedef struct packed {
    logic flash;
    logic eprom;
    logic sysreg;
    logic sdram;
    logic expansion;
  } target_sel_t;

  typedef struct packed {
    logic valid;
    logic [2:0] area;
    logic [AREA_ADDR_BITS-1:0] offset;
  } cpu_access_t;
endpackage : board_glue_pkg
`default_nettype wire

// [hw/strap_capture.sv]
// power-on capture of the boot mode jumper
`default_nettype none
module strap_capture
  import board_glue_pkg::*;
(
  input wire logic ref_clk, // board clock
  input wire logic reset_n, // async reset, active low
  input wire logic strap_closed, // jumper level, high when closed
  output logic mode_latched, // high: eprom boot mode
  output logic done // capture complete
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic mode_reg;
  logic mode_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    done_next = done_reg;
    if (!done_reg) begin
      if (cnt_reg == STRAP_SETTLE_CYCLES) begin
        mode_next = strap_closed;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 4'h0;
      mode_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
      done_reg <= done_next;
    end
  end

  assign mode_latched = mode_reg;
  assign done = done_reg;
endmodule : strap_capture
`default_nettype wire

// [hw/source_combiner.sv]
// or of active-low request sources with per-source mask
`default_nettype none
module source_combiner #(
  parameter int N = 2
) (
  input wire logic [N-1:0] src_n, // active-low sources
  input wire logic [N-1:0] src_mask, // high blocks that source
  output logic out_n // active low, low while any unmasked source low
);
  assign out_n = ~|(~src_n & ~src_mask);
endmodule : source_combiner
`default_nettype wire

// [hw/board_area_decode.sv]
// board area decode, boot mode swap, reset and nmi combining
`default_nettype none
// Operation
// [R1] normal boot: area 0 is monitor flash, 32-bit bus
// [R2] eprom boot: area 0 bus width becomes 16 bits
// [R3] eprom boot: eprom decoded in first 512 kbytes of area 0
// [R4] eprom boot: monitor flash moves from area 0 to area 2
// [R5] eprom boot: no expansion access through area 2
// [R6] jumper sampled at power-on; closed selects eprom boot
// [R7] area 1 is the system register area, with network controller
// [R8] area 3 is 64 Mbyte sdram, 32-bit bus in every mode
// [R9] software keeps top 0.5 Mbyte of area 3 for monitor work
// [R10] areas 4, 5, 6 and normal-mode area 2 go to expansion
// [R11] areas 5 and 6 pass only when the enable bit is set
// [R12] external reset point or any board source resets the cpu
// [R13] external nmi point joins board nmi sources for cpu nmi
// [R14] software can mask the external nmi point
// [R15] reset and nmi outputs active low, asserted by any unmasked source
module board_area_decode
  import board_glue_pkg::*;
(
  input wire logic ref_clk, // 25 MHz board clock
  input wire logic reset_n, // async reset, active low
  input wire logic boot_rom_mode_jumper, // high when jumper closed
  input wire cpu_access_t cpu_access, // decoded cpu cycle
  input wire logic mask_wr, // write strobe for nmi mask register
  input wire logic [7:0] mask_wdata, // data for nmi mask register
  input wire logic ext_reset_test_point_n, // external reset, active low
  input wire logic ext_nmi_test_point_n, // external nmi, active low
  input wire logic power_on_reset_n, // board power-on reset source
  input wire logic manual_reset_n, // board manual reset source
  input wire logic abort_nmi_n, // board abort switch nmi source
  output target_sel_t target_sel, // selected board target
  output logic [1:0] area_bus_width, // width code for current access
  output logic [AREA_ADDR_BITS-1:0] target_offset, // offset in target
  output logic area2_select, // expansion area 2 select
  output logic area5_select, // expansion area 5 select
  output logic area6_select, // expansion area 6 select
  output logic eprom_mode, // latched boot mode
  output logic [7:0] board_nmi_mask_register, // mask register value
  output logic cpu_reset_n, // cpu reset, active low
  output logic cpu_nmi_n // cpu nmi, active low
);
  logic mode_now;
  logic mode_done;
  logic rst_comb_n;
  logic nmi_comb_n;

  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  target_sel_t sel_reg;
  target_sel_t sel_next;
  logic [1:0] width_reg;
  logic [1:0] width_next;
  logic [AREA_ADDR_BITS-1:0] off_reg;
  logic [AREA_ADDR_BITS-1:0] off_next;
  logic a2_reg;
  logic a2_next;
  logic a5_reg;
  logic a5_next;
  logic a6_reg;
  logic a6_next;
  logic rst_reg;
  logic nmi_reg;
  logic mode_reg;

  strap_capture u_strap (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .strap_closed(boot_rom_mode_jumper), // [R6]
    .mode_latched(mode_now),
    .done(mode_done)
  );

  source_combiner #(.N(3)) u_reset_or (
    .src_n({ext_reset_test_point_n, power_on_reset_n, manual_reset_n}),
    .src_mask(3'h0), // [R12]
    .out_n(rst_comb_n)
  );

  source_combiner #(.N(2)) u_nmi_or (
    .src_n({ext_nmi_test_point_n, abort_nmi_n}), // [R13]
    .src_mask({mask_reg[MASK_EXT_NMI_BIT], 1'b0}), // [R14]
    .out_n(nmi_comb_n)
  );

  // mask register, software written
  always_comb begin
    mask_next = mask_reg;
    if (mask_wr) begin
      mask_next = mask_wdata;
    end
  end

  // area decode; no target until the boot strap is latched
  always_comb begin
    sel_next = '0;
    width_next = WIDTH_32;
    off_next = cpu_access.offset;
    a2_next = 1'b0;
    a5_next = 1'b0;
    a6_next = 1'b0;
    if (cpu_access.valid && mode_done) begin
      case (cpu_access.area)
        AREA_0: begin
          if (mode_now) begin
            width_next = WIDTH_16; // [R2]
            if (cpu_access.offset[AREA_ADDR_BITS-1:EPROM_ADDR_BITS] == '0)
            begin
              sel_next.eprom = 1'b1; // [R3]
            end
          end else begin
            sel_next.flash = 1'b1; // [R1]
            width_next = WIDTH_32; // [R1]
          end
        end
        AREA_1: begin
          sel_next.sysreg = 1'b1; // [R7]
        end
        AREA_2: begin
          if (mode_now) begin
            sel_next.flash = 1'b1; // [R4]
            width_next = WIDTH_32;
            a2_next = 1'b0; // [R5]
          end else begin
            sel_next.expansion = 1'b1; // [R10]
            a2_next = 1'b1; // [R10]
          end
        end
        AREA_3: begin
          sel_next.sdram = 1'b1; // [R8]
          width_next = WIDTH_32; // [R8]
        end
        AREA_4: begin
          sel_next.expansion = 1'b1; // [R10]
        end
        AREA_5: begin
          sel_next.expansion = mask_reg[MASK_UPPER_EN_BIT]; // [R11]
          a5_next = mask_reg[MASK_UPPER_EN_BIT]; // [R11]
        end
        AREA_6: begin
          sel_next.expansion = mask_reg[MASK_UPPER_EN_BIT]; // [R11]
          a6_next = mask_reg[MASK_UPPER_EN_BIT]; // [R11]
        end
        default: begin
          sel_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= NMI_MASK_RESET;
      sel_reg <= '0;
      width_reg <= WIDTH_32;
      off_reg <= '0;
      a2_reg <= 1'b0;
      a5_reg <= 1'b0;
      a6_reg <= 1'b0;
      rst_reg <= 1'b0;
      nmi_reg <= 1'b1;
      mode_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      sel_reg <= sel_next;
      width_reg <= width_next;
      off_reg <= off_next;
      a2_reg <= a2_next;
      a5_reg <= a5_next;
      a6_reg <= a6_next;
      rst_reg <= rst_comb_n; // [R15]
      nmi_reg <= nmi_comb_n; // [R15]
      mode_reg <= mode_now;
    end
  end

  assign target_sel = sel_reg;
  assign area_bus_width = width_reg;
  assign target_offset = off_reg;
  assign area2_select = a2_reg;
  assign area5_select = a5_reg;
  assign area6_select = a6_reg;
  assign eprom_mode = mode_reg;
  assign board_nmi_mask_register = mask_reg;
  assign cpu_reset_n = rst_reg;
  assign cpu_nmi_n = nmi_reg;
endmodule : board_area_decode
`default_nettype wire

// [test/board_area_decode_sva.sv]
// assertions on the board area decode ports
`default_nettype none
module board_area_decode_sva
  import board_glue_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic reset_n, // reset
  input wire cpu_access_t cpu_access, // cpu cycle
  input wire logic ext_reset_test_point_n, // ext reset
  input wire logic ext_nmi_test_point_n, // ext nmi
  input wire logic power_on_reset_n, // por
  input wire logic manual_reset_n, // manual
  input wire logic abort_nmi_n, // abort
  input wire target_sel_t target_sel, // target
  input wire logic [1:0] area_bus_width, // width
  input wire logic area2_select, // area 2
  input wire logic area5_select, // area 5
  input wire logic area6_select, // area 6
  input wire logic eprom_mode, // mode
  input wire logic [7:0] board_nmi_mask_register, // mask
  input wire logic cpu_reset_n, // cpu reset
  input wire logic cpu_nmi_n // cpu nmi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] up_reg;
  logic [3:0] up_next;
  logic ready;
  // edges since release, past the strap capture
  always_comb up_next = (up_reg == 4'hf) ? up_reg : up_reg + 4'h1;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) up_reg <= 4'h0;
    else up_reg <= up_next;
  end
  assign ready = up_reg >= 4'hb;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take(logic [2:0] a);
    ready && cpu_access.valid && cpu_access.area == a;
  endsequence
  property p_flash;
    s_take(AREA_0) ##0 !eprom_mode |=>
      target_sel.flash && area_bus_width == WIDTH_32;
  endproperty
  a_flash: assert property (p_flash) else $error("area 0 flash");
  property p_eprom;
    s_take(AREA_0) ##0 (eprom_mode && cpu_access.offset < 26'h80000) |=>
      target_sel.eprom && area_bus_width == WIDTH_16;
  endproperty
  a_eprom: assert property (p_eprom) else $error("eprom");
  property p_area2;
    s_take(AREA_2) |=> $past(eprom_mode) ?
      (target_sel.flash && !area2_select) : area2_select;
  endproperty
  a_area2: assert property (p_area2) else $error("area 2");
  property p_sysreg;
    s_take(AREA_1) |=> target_sel.sysreg;
  endproperty
  a_sysreg: assert property (p_sysreg) else $error("area 1");
  property p_sdram;
    s_take(AREA_3) |=> target_sel.sdram && area_bus_width == WIDTH_32;
  endproperty
  a_sdram: assert property (p_sdram) else $error("area 3");
  property p_upper;
    ready && cpu_access.valid &&
      (cpu_access.area == AREA_5 || cpu_access.area == AREA_6) |=>
      area5_select == ($past(cpu_access.area) == AREA_5 &&
      $past(board_nmi_mask_register[MASK_UPPER_EN_BIT])) &&
      area6_select == ($past(cpu_access.area) == AREA_6 &&
      $past(board_nmi_mask_register[MASK_UPPER_EN_BIT])) &&
      target_sel.expansion ==
      $past(board_nmi_mask_register[MASK_UPPER_EN_BIT]);
  endproperty
  a_upper: assert property (p_upper) else $error("area 5/6");
  property p_reset;
    1'b1 |=> cpu_reset_n == ($past(ext_reset_test_point_n) &
      $past(power_on_reset_n) & $past(manual_reset_n));
  endproperty
  a_reset: assert property (p_reset) else $error("reset");
  property p_nmi;
    1'b1 |=> cpu_nmi_n == ($past(abort_nmi_n) &
      ($past(ext_nmi_test_point_n) |
      $past(board_nmi_mask_register[MASK_EXT_NMI_BIT])));
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_strap;
    ready |=> $stable(eprom_mode);
  endproperty
  a_strap: assert property (p_strap) else $error("mode moved");
endmodule : board_area_decode_sva
`default_nettype wire

// [test/cpu_bus_model.sv]
// host cpu bus model, one access per call
`default_nettype none
module cpu_bus_model
  import board_glue_pkg::*;
(
  input wire logic ref_clk, // clock
  output var cpu_access_t cpu_access // cpu cycle
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cpu_access = '0;
  task automatic access(input logic [2:0] a, input logic [25:0] o);
    if (a == AREA_3 && o[25:19] == 7'h7f) o[25:19] = 7'h7e;
    @(posedge ref_clk) #1;
    cpu_access = {1'b1, a, o};
    @(posedge ref_clk) #1;
    // released: flipped so no stale value lingers
    cpu_access = {1'b0, ~a, ~o};
  endtask : access
endmodule : cpu_bus_model
`default_nettype wire

// [test/board_area_decode_tb.sv]
// self-checking bench for the board area decode
`default_nettype none
module board_area_decode_tb
  import board_glue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic boot_rom_mode_jumper = 1'b0;
  logic mask_wr = 1'b0;
  logic [7:0] mask_wdata = 8'h00;
  logic [4:0] src_n = 5'h1f;
  logic mode = 1'b0;
  logic [7:0] mask = 8'h00;
  cpu_access_t cpu_access;
  target_sel_t target_sel;
  logic [1:0] area_bus_width;
  logic [25:0] target_offset;
  logic area2_select, area5_select, area6_select, eprom_mode;
  logic [7:0] board_nmi_mask_register;
  logic cpu_reset_n, cpu_nmi_n;
  wire ext_reset_test_point_n, ext_nmi_test_point_n, abort_nmi_n;
  wire power_on_reset_n, manual_reset_n;
  int n_mismatch = 0;
  int checked = 0;
  assign {ext_reset_test_point_n, ext_nmi_test_point_n, power_on_reset_n,
    manual_reset_n, abort_nmi_n} = src_n;
  initial forever #20 ref_clk = ~ref_clk;
  board_area_decode u_board_area_decode (.ref_clk, .reset_n,
    .boot_rom_mode_jumper, .cpu_access, .mask_wr, .mask_wdata,
    .ext_reset_test_point_n, .ext_nmi_test_point_n, .power_on_reset_n,
    .manual_reset_n, .abort_nmi_n, .target_sel, .area_bus_width,
    .target_offset, .area2_select, .area5_select, .area6_select,
    .eprom_mode, .board_nmi_mask_register, .cpu_reset_n, .cpu_nmi_n);
  cpu_bus_model u_cpu_bus_model (.ref_clk, .cpu_access);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic start(input logic j);
    @(posedge ref_clk) #1;
    reset_n = 1'b0;
    boot_rom_mode_jumper = j;
    mode = j;
    mask = 8'h00;
    repeat (3) @(posedge ref_clk);
    #1;
    // reset levels: cpu reset low, nmi high, no target
    check({cpu_reset_n, cpu_nmi_n, target_sel}, 7'h20);
    reset_n = 1'b1;
    repeat (11) @(posedge ref_clk);
    #1;
    boot_rom_mode_jumper = ~j;
    check(eprom_mode, j);
  endtask : start
  task automatic write_mask(input logic [7:0] v);
    @(posedge ref_clk) #1;
    mask_wr = 1'b1;
    mask_wdata = v;
    mask = v;
    @(posedge ref_clk) #1;
    mask_wr = 1'b0;
    check(board_nmi_mask_register, v);
  endtask : write_mask
  task automatic probe(input logic [2:0] a, input logic [25:0] o);
    logic [7:0] e;
    logic [1:0] w;
    logic [25:0] eo;
    case (a)
      AREA_0: e = !mode ? 8'h80 : (o < 26'h80000 ? 8'h40 : 8'h00);
      AREA_1: e = 8'h20;
      AREA_2: e = mode ? 8'h80 : 8'h0c;
      AREA_3: e = 8'h10;
      AREA_4: e = 8'h08;
      AREA_5: e = mask[1] ? 8'h0a : 8'h00;
      AREA_6: e = mask[1] ? 8'h09 : 8'h00;
      default: e = 8'h00;
    endcase
    w = (a == AREA_0 && mode) ? WIDTH_16 : WIDTH_32;
    eo = o;
    if (a == AREA_3 && o[25:19] == 7'h7f) begin
      eo[25:19] = 7'h7e;
    end
    u_cpu_bus_model.access(a, o);
    check(target_sel, e[7:3]);
    check({area2_select, area5_select, area6_select},
      e[2:0]);
    check(target_offset, eo);
    if (a == AREA_0 || a == AREA_3) begin
      check(area_bus_width, w);
    end
  endtask : probe
  task automatic t_decode;
    for (int a = 0; a < 8; a++) probe(3'(a), 26'h3f7fffc);
    probe(AREA_3, 26'h3fffff0);
    write_mask(8'h02);
    probe(AREA_5, 26'h0000010);
    probe(AREA_6, 26'h3ffffff);
  endtask : t_decode
  task automatic t_sources(input logic [7:0] m);
    write_mask(m);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk) #1 src_n = ~(5'h01 << i);
      @(posedge ref_clk) #1;
      check({cpu_reset_n, cpu_nmi_n}, {src_n[4] & src_n[2] & src_n[1],
        src_n[0] & (src_n[3] | m[0])});
    end
    src_n = 5'h1f;
  endtask : t_sources
  task automatic t_eprom;
    start(1'b1);
    probe(AREA_0, 26'h0000000);
    probe(AREA_0, 26'h007fffe);
    probe(AREA_0, 26'h0080000);
    probe(AREA_2, 26'h0001000);
    probe(AREA_3, 26'h3f7fffc);
  endtask : t_eprom
  initial begin
    start(1'b0);
    t_decode();
    t_sources(8'h00);
    t_sources(8'h01);
    t_eprom();
    end_of_test();
  end
endmodule : board_area_decode_tb
bind board_area_decode board_area_decode_sva u_board_area_decode_sva (
  .ref_clk, .reset_n, .cpu_access, .ext_reset_test_point_n,
  .ext_nmi_test_point_n, .power_on_reset_n, .manual_reset_n, .abort_nmi_n,
  .target_sel, .area_bus_width, .area2_select, .area5_select, .area6_select,
  .eprom_mode, .board_nmi_mask_register, .cpu_reset_n, .cpu_nmi_n);
`default_nettype wire
